// file: rtl/lcd_serial_command_addressing.sv
/*
  Serial receiver, command decoder and address counter of an LCD driver.
  Assumes link pins asynchronous to i_clock; serial clock well below 25 MHz.
*/
`timescale 1ns/1ps
module lcd_serial_command_addressing (
  input  wire logic                    i_clock,           // 100 MHz clock
  input  wire logic                    i_arst_n,          // async reset, low
  input  wire logic                    i_reset_n,         // device reset pin, low
  input  wire logic                    i_chip_enable_n,   // link chip enable, low
  input  wire logic                    i_serial_clock,    // link serial clock
  input  wire logic                    i_serial_data_in,  // link data
  input  wire logic                    i_data_command,    // high data, low command
  output logic                         o_ram_we,          // ram write strobe
  output logic [lcd_cmd_pkg::COL_W-1:0]  o_ram_column,    // ram write column
  output logic [lcd_cmd_pkg::BANK_W-1:0] o_ram_bank,      // ram write bank
  output logic [7:0]                   o_ram_data,        // ram write data
  output lcd_cmd_pkg::config_type      o_config,          // configuration fields
  output lcd_cmd_pkg::pointer_type     o_pointer          // address pointer
);
  import lcd_cmd_pkg::*;

  // ==========================================================
  // reset release and pin synchronisers
  logic [1:0] rst_sync_q;
  logic       rst_n;
  always_ff @(posedge i_clock or negedge i_arst_n) begin
    if (!i_arst_n) rst_sync_q <= 2'h0;
    else           rst_sync_q <= {rst_sync_q[0], 1'h1};
  end
  assign rst_n = rst_sync_q[1];

  logic [4:0] meta_q, sync_q, sync_d;
  always_comb sync_d = {i_reset_n, i_chip_enable_n, i_serial_clock,
                        i_serial_data_in, i_data_command};
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      meta_q <= 5'h18;
      sync_q <= 5'h18;
    end else begin
      meta_q <= sync_d;
      sync_q <= meta_q;
    end
  end

  logic dev_rst_n, ce_n, sclk, serial_data_in, dc;
  always_comb {dev_rst_n, ce_n, sclk, serial_data_in, dc} = sync_q;

  logic sclk_prev_q;
  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) sclk_prev_q <= 1'h0;
    else        sclk_prev_q <= sclk;
  end
  logic sclk_rise;
  assign sclk_rise = sclk & ~sclk_prev_q;

  // ==========================================================
  // serial receiver
  rx_state_type state_q, state_d;
  logic [2:0]   cnt_q, cnt_d;
  logic [6:0]   shift_q, shift_d;
  logic         byte_done;
  logic [7:0]   byte_val;
  logic         byte_dc;

  always_comb begin
    state_d   = state_q;
    cnt_d     = cnt_q;
    shift_d   = shift_q;
    byte_done = 1'h0;
    byte_val  = {shift_q, serial_data_in};
    byte_dc   = dc;
    if (!dev_rst_n || ce_n) begin
      state_d = RX_IDLE;
      cnt_d   = 3'h0;
    end else begin
      unique case (state_q)
        RX_IDLE: begin
          state_d = RX_SHIFT;
        end
        RX_SHIFT: begin
          if (sclk_rise) begin
            shift_d = {shift_q[5:0], serial_data_in};
            cnt_d   = cnt_q + 3'h1;
            if (cnt_q == BIT_LAST) begin
              byte_done = 1'h1;
              cnt_d     = 3'h0;
            end
          end
        end
      endcase
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      state_q <= RX_IDLE;
      cnt_q   <= 3'h0;
      shift_q <= 7'h00;
    end else begin
      state_q <= state_d;
      cnt_q   <= cnt_d;
      shift_q <= shift_d;
    end
  end

  // ==========================================================
  // address advance
  function automatic pointer_type advance(input pointer_type p, input logic vert);
    pointer_type n;
    n = p;
    if (p.column_pointer == COL_LAST && p.bank_pointer == BANK_LAST) begin
      n = '0;
    end else if (vert) begin
      if (p.bank_pointer == BANK_LAST) begin
        n.bank_pointer   = '0;
        n.column_pointer = p.column_pointer + 7'h01;
      end else begin
        n.bank_pointer = p.bank_pointer + 4'h1;
      end
    end else begin
      if (p.column_pointer == COL_LAST) begin
        n.column_pointer = '0;
        n.bank_pointer   = p.bank_pointer + 4'h1;
      end else begin
        n.column_pointer = p.column_pointer + 7'h01;
      end
    end
    return n;
  endfunction : advance

  // ==========================================================
  // command decode and data write
  config_type    cfg_q, cfg_d;
  pointer_type   ptr_q, ptr_d;
  ram_write_type wr_q, wr_d;

  always_comb begin
    cfg_d = cfg_q;
    ptr_d = ptr_q;
    wr_d  = '0;
    wr_d.column = wr_q.column;
    wr_d.bank   = wr_q.bank;
    wr_d.data   = wr_q.data;
    if (!dev_rst_n) begin
      cfg_d = CFG_RESET;
      ptr_d = '0;
    end else if (byte_done && byte_dc) begin
      wr_d.valid  = 1'h1;
      wr_d.column = ptr_q.column_pointer;
      wr_d.bank   = ptr_q.bank_pointer;
      wr_d.data   = (ptr_q.bank_pointer == BANK_LAST) ? {7'h00, byte_val[0]}
                                                      : byte_val;
      ptr_d = advance(ptr_q, cfg_q.vertical);
    end else if (byte_done) begin
      if (byte_val[7:3] == 5'h04) begin
        cfg_d.power_down_bit = byte_val[2];
        cfg_d.vertical       = byte_val[1];
        cfg_d.extended       = byte_val[0];
      end else if (!cfg_q.extended) begin
        if (byte_val[7]) ptr_d.column_pointer = byte_val[6:0];
        else if (byte_val[7:4] == 4'h4) ptr_d.bank_pointer = byte_val[3:0];
        else if (byte_val[7:3] == 5'h01 && !byte_val[1]) begin
          cfg_d.display_d = byte_val[2];
          cfg_d.display_e = byte_val[0];
        end else if (byte_val[7:1] == 7'h08) cfg_d.voltage_range_select = byte_val[0];
      end else begin
        if (byte_val[7]) cfg_d.operating_voltage_setting = byte_val[6:0];
        else if (byte_val[7:2] == 6'h01) cfg_d.temp_coefficient = byte_val[1:0];
        else if (byte_val[7:2] == 6'h02) cfg_d.multiplier_stages = byte_val[1:0];
        else if (byte_val[7:3] == 5'h02) cfg_d.bias_select = byte_val[2:0];
      end
    end
  end

  always_ff @(posedge i_clock or negedge rst_n) begin
    if (!rst_n) begin
      cfg_q <= CFG_RESET;
      ptr_q <= '0;
      wr_q  <= '0;
    end else begin
      cfg_q <= cfg_d;
      ptr_q <= ptr_d;
      wr_q  <= wr_d;
    end
  end

  assign o_ram_we     = wr_q.valid;
  assign o_ram_column = wr_q.column;
  assign o_ram_bank   = wr_q.bank;
  assign o_ram_data   = wr_q.data;
  assign o_config     = cfg_q;
  assign o_pointer    = ptr_q;
endmodule : lcd_serial_command_addressing

// file: rtl/lcd_cmd_pkg.sv
/*
  Constants, types and state for the LCD serial command front end.
  Assumes a single 100 MHz system clock; link pins are asynchronous.
*/
// How it works
// - vertical mode: bank advances per byte, past 8 wraps, column advances
// - horizontal mode: column advances per byte, past 101 wraps, bank advances
// - byte stored at column 101 bank 8 returns both pointers to zero
// - byte with select low is decoded as command, never stored
// - byte with select high is stored at pointer, then pointer advances
// - data/command select sampled at the eighth serial clock rising edge
// - bytes travel MSB first; bit 7 assembled first
// - chip enable high: clock edges ignored, receiver held initial
// - falling chip enable starts a transfer and enables reception
// - serial data captured on each serial clock rising edge while enabled
// - enable still low after a byte: next rising edge is bit 7
// - last bit completes only on its rising edge; enable rising first drops the partial byte
// - reset aborts partial byte, nothing stored, configuration reset with power-down bit set
// - enable low at reset release: ready for bit 7 at once
// - commands accepted in any order
// - basic set: 0100 yyyy loads bank pointer
// - basic set: 1xxxxxxx loads column pointer
// - extended set: 000001 tt loads temperature coefficient
// - extended set: 000010 ss loads multiplier stages
// - extended set: 00010 bbb loads bias select
// - extended select bit picks basic or extended command set
// - reset clears column and bank pointers
// - bank 8 writes store only the data LSB
package lcd_cmd_pkg;
  localparam int unsigned COL_W    = 7;
  localparam int unsigned BANK_W   = 4;
  localparam logic [6:0]  COL_LAST  = 7'h65;
  localparam logic [3:0]  BANK_LAST = 4'h8;
  localparam logic [2:0]  BIT_LAST  = 3'h7;
  localparam logic        PD_RESET  = 1'h1;

  typedef struct packed {
    logic       power_down_bit;
    logic       vertical;
    logic       extended;
    logic       display_d;
    logic       display_e;
    logic       voltage_range_select;
    logic [1:0] temp_coefficient;
    logic [1:0] multiplier_stages;
    logic [2:0] bias_select;
    logic [6:0] operating_voltage_setting;
  } config_type;

  localparam config_type CFG_RESET = '{power_down_bit: PD_RESET, default: '0};

  typedef struct packed {
    logic [COL_W-1:0]  column_pointer;
    logic [BANK_W-1:0] bank_pointer;
  } pointer_type;

  typedef struct packed {
    logic              valid;
    logic [COL_W-1:0]  column;
    logic [BANK_W-1:0] bank;
    logic [7:0]        data;
  } ram_write_type;

  typedef enum logic [1:0] {
    RX_IDLE  = 2'b01,
    RX_SHIFT = 2'b10
  } rx_state_type;
endpackage : lcd_cmd_pkg

// file: dv/lcd_sca_checker.sv
/* port checker for the lcd command front end
   bound by the testbench to the top module */
`timescale 1ns/1ps
module lcd_sca_checker (
  input wire logic                     i_clock,         // clock
  input wire logic                     i_arst_n,        // reset, low
  input wire logic                     i_reset_n,       // pin reset, low
  input wire logic                     i_chip_enable_n, // enable, low
  input wire logic                     o_ram_we,        // strobe
  input wire logic [6:0]               o_ram_column,    // column
  input wire logic [3:0]               o_ram_bank,      // bank
  input wire lcd_cmd_pkg::config_type  o_config,        // config
  input wire lcd_cmd_pkg::pointer_type o_pointer        // pointer
);
  import lcd_cmd_pkg::*;
  // ==========
  // write strobe, address counter, idle and reset checks
  default clocking @(posedge i_clock); endclocking
  default disable iff (!i_arst_n);
  logic hz;
  logic vt;
  assign hz = o_ram_we && !o_config.vertical;
  assign vt = o_ram_we && o_config.vertical;
  property p_we; o_ram_we |=> !o_ram_we; endproperty
  property p_hz; hz && o_ram_column != COL_LAST
    |=> o_pointer == {o_ram_column + 7'h01, o_ram_bank}; endproperty
  property p_hwrap; hz && o_ram_column == COL_LAST && o_ram_bank != BANK_LAST
    |=> o_pointer == {7'h00, o_ram_bank + 4'h1}; endproperty
  property p_vt; vt && o_ram_bank != BANK_LAST
    |=> o_pointer == {o_ram_column, o_ram_bank + 4'h1}; endproperty
  property p_vwrap; vt && o_ram_bank == BANK_LAST && o_ram_column != COL_LAST
    |=> o_pointer == {o_ram_column + 7'h01, 4'h0}; endproperty
  property p_last; o_ram_we && o_ram_column == COL_LAST && o_ram_bank == BANK_LAST
    |=> o_pointer == 11'h000; endproperty
  property p_idle; i_chip_enable_n [*6] |-> !o_ram_we; endproperty
  property p_rst; !i_reset_n [*6]
    |-> o_pointer == 11'h000 && !o_ram_we && o_config == CFG_RESET; endproperty
  a_we: assert property (p_we)
    else $error("write strobe too long");
  a_hz: assert property (p_hz)
    else $error("column step wrong");
  a_hwrap: assert property (p_hwrap)
    else $error("column wrap wrong");
  a_vt: assert property (p_vt)
    else $error("bank step wrong");
  a_vwrap: assert property (p_vwrap)
    else $error("bank wrap wrong");
  a_last: assert property (p_last)
    else $error("last address wrap wrong");
  a_idle: assert property (p_idle)
    else $error("write while disabled");
  a_rst: assert property (p_rst)
    else $error("reset state wrong");
  c_vwrap: cover property (vt && o_ram_bank == BANK_LAST);
  c_hwrap: cover property (hz && o_ram_column == COL_LAST);
  c_ext: cover property (o_config.extended);
endmodule : lcd_sca_checker

// file: dv/lcd_host_model.sv
/* host side of the write-only serial link
   called by the testbench through its tasks */
`timescale 1ns/1ps
module lcd_host_model (
  output logic o_chip_enable_n,  // enable, low
  output logic o_serial_clock,   // serial clock
  output logic o_serial_data_in, // data
  output logic o_data_command    // high data
);
  localparam realtime HALF = 62.5;
  initial begin
    o_chip_enable_n = 1'h1;
    o_serial_clock = 1'h0;
    o_serial_data_in = 1'h0;
    o_data_command = 1'h0;
  end
  // callers keep pointers and commands legal
  task automatic send(input logic [7:0] b, input logic dc_v, input int n);
    if (o_chip_enable_n) begin
      o_chip_enable_n = 1'h0;
      #HALF;
    end
    for (int i = 7; i > 7 - n; i--) begin
      o_serial_data_in = b[i];
      o_data_command = dc_v;
      #HALF o_serial_clock = 1'h1;
      #HALF o_serial_clock = 1'h0;
    end
  endtask : send
  task automatic stop();
    o_chip_enable_n = 1'h1;
    o_serial_data_in = ~o_serial_data_in;
    o_data_command = ~o_data_command;
  endtask : stop
endmodule : lcd_host_model

// file: dv/lcd_serial_command_addressing_test.sv
/* testbench of the lcd command front end
   needs the host model and the checker */
`timescale 1ns/1ps
module lcd_serial_command_addressing_test;
  import lcd_cmd_pkg::*;
  logic        i_clock    = 1'h0;
  logic        i_arst_n   = 1'h0;
  logic        i_reset_n  = 1'h1;
  logic        ce_n, sclk, serial_data_in, dc, we;
  logic [6:0]  col;
  logic [3:0]  bank;
  logic [7:0]  data;
  config_type  cfg;
  pointer_type ptr;
  int          n_mismatch = 0;
  int          cmp_count  = 0;
  logic [18:0] wr_q[$];
  always #5 i_clock = ~i_clock;
  always @(negedge i_clock) if (we) wr_q.push_back({col, bank, data});
  lcd_host_model i_host (.o_chip_enable_n(ce_n), .o_serial_clock(sclk),
    .o_serial_data_in(serial_data_in), .o_data_command(dc));
  lcd_serial_command_addressing i_dut (.i_clock(i_clock), .i_arst_n(i_arst_n),
    .i_reset_n(i_reset_n), .i_chip_enable_n(ce_n), .i_serial_clock(sclk),
    .i_serial_data_in(serial_data_in), .i_data_command(dc), .o_ram_we(we), .o_ram_column(col),
    .o_ram_bank(bank), .o_ram_data(data), .o_config(cfg), .o_pointer(ptr));
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    cmp_count++;
    if (seen !== exp) begin
      n_mismatch++;
      $display("[FAIL] %0t got %h expected %h", $time, seen, exp);
    end
  endtask : chk
  task automatic bytes(input logic [7:0] b[], input logic dc_v);
    foreach (b[i]) i_host.send(b[i], dc_v, 8);
  endtask : bytes
  task automatic settle();
    i_host.stop();
    repeat (8) @(negedge i_clock);
  endtask : settle
  task automatic chk_wr(input logic [18:0] e[]);
    chk(wr_q.size(), e.size());
    foreach (e[i]) chk(wr_q[i], e[i]);
    wr_q.delete();
  endtask : chk_wr
  task automatic t_cfg();
    bytes('{8'hE4, 8'h45, 8'h21, 8'h06, 8'h0B, 8'h15, 8'hC5}, 1'h0);
    bytes('{8'h20, 8'h05, 8'h0D, 8'h11, 8'h00}, 1'h0);
    settle();
    chk(cfg, 20'h1EEC5);
    chk(ptr, {7'h64, 4'h5});
    chk(wr_q.size(), 0);
  endtask : t_cfg
  task automatic t_hz();
    bytes('{8'h47}, 1'h0);
    bytes('{8'hA5, 8'h3C, 8'h81}, 1'h1);
    settle();
    chk_wr('{{7'h64, 4'h7, 8'hA5}, {7'h65, 4'h7, 8'h3C}, {7'h00, 4'h8, 8'h01}});
    chk(ptr, {7'h01, 4'h8});
  endtask : t_hz
  task automatic t_vt();
    i_host.send(8'hFF, 1'h1, 3);
    settle();
    bytes('{8'h22, 8'hE4, 8'h47}, 1'h0);
    bytes('{8'h5A, 8'hC3}, 1'h1);
    bytes('{8'h48}, 1'h0);
    bytes('{8'h01}, 1'h1);
    settle();
    chk_wr('{{7'h64, 4'h7, 8'h5A}, {7'h64, 4'h8, 8'h01}, {7'h65, 4'h8, 8'h01}});
    chk(ptr, 11'h000);
  endtask : t_vt
  task automatic t_rst();
    bytes('{8'hE4, 8'h21}, 1'h0);
    i_host.send(8'hAA, 1'h1, 4);
    @(negedge i_clock) i_reset_n = 1'h0;
    repeat (8) @(negedge i_clock);
    i_reset_n = 1'h1;
    repeat (8) @(negedge i_clock);
    bytes('{8'h43}, 1'h0);
    settle();
    chk(cfg, CFG_RESET);
    chk(ptr, {7'h00, 4'h3});
    chk(wr_q.size(), 0);
  endtask : t_rst
  task automatic print_verdict();
    $display("mismatches %0d compares %0d", n_mismatch, cmp_count);
    if (n_mismatch == 0 && cmp_count > 0) $display("TEST PASSED");
    else $display("TEST FAILED");
    $finish;
  endtask : print_verdict
  initial begin
    repeat (6) @(negedge i_clock);
    i_arst_n = 1'h1;
    repeat (6) @(negedge i_clock);
    chk(cfg, CFG_RESET);
    chk(ptr, 11'h000);
    t_cfg();
    t_hz();
    t_vt();
    t_rst();
    print_verdict();
  end
  initial begin
    #200us;
    n_mismatch++;
    print_verdict();
  end
endmodule : lcd_serial_command_addressing_test
bind lcd_serial_command_addressing lcd_sca_checker i_chk (.i_clock(i_clock),
  .i_arst_n(i_arst_n), .i_reset_n(i_reset_n), .i_chip_enable_n(i_chip_enable_n),
  .o_ram_we(o_ram_we), .o_ram_column(o_ram_column), .o_ram_bank(o_ram_bank),
  .o_config(o_config), .o_pointer(o_pointer));
